/* File: ltac_pkg.sv */
// package for the lookup table access controller
// holds register offsets, field positions, reset values and enums
package ltac_pkg;
  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [15:0] LTAC_OFS_IDX0 = 16'h0410;
  localparam logic [15:0] LTAC_OFS_IDX1 = 16'h0414;
  localparam logic [15:0] LTAC_OFS_LKCTL = 16'h0418;
  localparam logic [15:0] LTAC_OFS_SMCTL = 16'h041C;
  localparam logic [15:0] LTAC_OFS_ENT1 = 16'h0420;
  localparam logic [15:0] LTAC_OFS_ENT2 = 16'h0424;
  localparam logic [15:0] LTAC_OFS_ENT3 = 16'h0428;
  localparam logic [15:0] LTAC_OFS_ENT4 = 16'h042C;
  localparam logic [15:0] LTAC_OFS_ENT4_LAST = 16'h042F;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int LTAC_BIT_GO = 7;
  localparam int LTAC_BIT_RDY = 6;
  localparam int LTAC_BIT_RDY_OR_END = 5;
  localparam int LTAC_BIT_DIRECT = 2;
  localparam int LTAC_BIT_TSEL = 1;
  localparam int LTAC_BIT_SMOP = 0;
  localparam int LTAC_CNT_LSB = 16;
  localparam int LTAC_CNT_W = 14;
  localparam int LTAC_FGID_LSB = 16;
  localparam int LTAC_FGID_W = 7;
  localparam int LTAC_DIRECT_W = 12;
  localparam int LTAC_RMIDX_W = 6;
  localparam int LTAC_STIDX_W = 4;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [31:0] LTAC_RST_WORD = 32'h0000_0000;
  // --------------------------------------------------------------
  // enumerations
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    LTAC_ACT_NOP = 2'h0,
    LTAC_ACT_WRITE = 2'h1,
    LTAC_ACT_READ = 2'h2,
    LTAC_ACT_SEARCH = 2'h3
  } ltac_act_type;
  typedef enum logic [1:0] {
    LTAC_ST_IDLE = 2'h0,
    LTAC_ST_REQ = 2'h1,
    LTAC_ST_WAIT = 2'h3,
    LTAC_ST_HOLD = 2'h2
  } ltac_state_type;
endpackage : ltac_pkg

/* File: ltac_eng_if.sv */
// carrier between the access controller and its engine request stage
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface ltac_eng_if;
  logic req;
  logic [1:0] op;
  logic direct;
  logic [11:0] index;
  logic [6:0] group_id;
  logic [47:0] key;
  logic [1:0] table_sel;
  logic [127:0] wdata;
  logic done;
  logic valid;
  logic last;
  logic [127:0] rdata;
  logic [13:0] count;
  modport ctrl (output req, op, direct, index, group_id, key, table_sel, wdata,
    input done, valid, last, rdata, count);
  modport stage (input req, op, direct, index, group_id, key, table_sel, wdata,
    output done, valid, last, rdata, count);
endinterface : ltac_eng_if
`default_nettype wire

/* File: ltac_req_stage.sv */
// register stage between controller and lookup engine pins
// assumes the engine answers with a one-cycle ack pulse
`timescale 1ns/1ps
`default_nettype none
module ltac_req_stage (
  input wire logic clk_sys,
  input wire logic reset,
  ltac_eng_if.stage bus,
  // engine side
  output logic eng_req,
  output logic [1:0] eng_op,
  output logic eng_direct,
  output logic [11:0] eng_index,
  output logic [6:0] eng_group_id,
  output logic [47:0] eng_key,
  output logic [1:0] eng_table,
  output logic [127:0] eng_wdata,
  input wire logic eng_ack,
  input wire logic eng_valid,
  input wire logic eng_last,
  input wire logic [127:0] eng_rdata,
  input wire logic [13:0] eng_count
);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      eng_req <= 1'b0;
      eng_op <= 2'h0;
      eng_direct <= 1'b0;
      eng_index <= 12'h000;
      eng_group_id <= 7'h00;
      eng_key <= 48'h0;
      eng_table <= 2'h0;
      eng_wdata <= 128'h0;
    end else begin
      eng_req <= bus.req;
      eng_op <= bus.op;
      eng_direct <= bus.direct;
      eng_index <= bus.index;
      eng_group_id <= bus.group_id;
      eng_key <= bus.key;
      eng_table <= bus.table_sel;
      eng_wdata <= bus.wdata;
    end
  end
  assign bus.done = eng_ack;
  assign bus.valid = eng_valid;
  assign bus.last = eng_last;
  assign bus.rdata = eng_rdata;
  assign bus.count = eng_count;
endmodule : ltac_req_stage
`default_nettype wire

/* File: ltac_ctrl.sv */
// lookup table access controller: registers and operation sequencing
// assumes a synchronous register port on clk_sys and an engine acking each op
// How it works
// R1 - lookup action 00 is no operation, 01 writes, 10 reads and 11 searches.
// R2 - software sets lookup go bit 7, hardware clears it when the op completes.
// R3 - ready bit 6 sets when a searched entry is held, clears on reading 0x042F.
// R4 - bit 5 reads one when an entry is ready or the search has ended.
// R5 - on search end the valid entry count appears in bits 29:16.
// R6 - bit 2 set selects direct indexing, clear selects hashed indexing.
// R7 - multicast table uses index bits 21:16, static table bits 19:16.
// R8 - table select bit 1 picks multicast table when set, static when clear.
// R9 - static/multicast op bit 0 set reads and clear writes.
// R10 - software sets static go bit 7, hardware clears it when access ends.
// R11 - four entry words serve lookup and static, multicast uses word 2 only.
// R12 - entry word meaning follows the table of the current access.
// R13 - hashed mode keys on group id bits 22:16 plus the 48-bit address.
// R14 - direct mode uses low address index bits 11:0 as entry address.
// R15 - software waits for go to read zero before changing anything.
// R16 - a searched entry is held until word 4 is read, then search advances.
`timescale 1ns/1ps
`default_nettype none
module ltac_ctrl
  import ltac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // lookup engine
  output logic eng_req,
  output logic [1:0] eng_op,
  output logic eng_direct,
  output logic [11:0] eng_index,
  output logic [6:0] eng_group_id,
  output logic [47:0] eng_key,
  output logic [1:0] eng_table,
  output logic [127:0] eng_wdata,
  input wire logic eng_ack,
  input wire logic eng_valid,
  input wire logic eng_last,
  input wire logic [127:0] eng_rdata,
  input wire logic [13:0] eng_count
);
  import ltac_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] idx0_q, idx1_q;
  logic [31:0] ent_q [4];
  logic [1:0] lk_act_q;
  logic lk_direct_q, lk_go_q, lk_rdy_q, lk_end_q;
  logic [1:0] lk_rsv_q;
  logic [LTAC_CNT_W-1:0] lk_cnt_q;
  logic [5:0] sm_idx_q;
  logic [4:0] sm_rsv_q;
  logic sm_go_q, sm_tsel_q, sm_op_q;
  ltac_state_type st_q;
  logic sm_active_q;
  ltac_eng_if bus ();

  wire word_wr = reg_wr;
  wire lk_start = word_wr && reg_addr == LTAC_OFS_LKCTL && reg_wdata[LTAC_BIT_GO]
    && !lk_go_q && !sm_go_q && reg_wdata[1:0] != LTAC_ACT_NOP;
  wire sm_start = word_wr && reg_addr == LTAC_OFS_SMCTL && reg_wdata[LTAC_BIT_GO]
    && !lk_go_q && !sm_go_q;
  wire ent4_rd = reg_rd && reg_addr[15:2] == LTAC_OFS_ENT4_LAST[15:2]; // [R3]
  wire eng_busy = st_q != LTAC_ST_IDLE;

  // ------------------------------------------------------------
  // index, lookup and static/multicast control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idx0_q <= LTAC_RST_WORD;
      idx1_q <= LTAC_RST_WORD;
      lk_act_q <= LTAC_ACT_NOP;
      lk_direct_q <= 1'b0;
      lk_rsv_q <= 2'h0;
      sm_idx_q <= 6'h00;
      sm_rsv_q <= 5'h00;
      sm_tsel_q <= 1'b0;
      sm_op_q <= 1'b0;
    end else if (word_wr && !eng_busy) begin
      if (reg_addr == LTAC_OFS_IDX0) begin
        idx0_q <= {reg_wdata[31], 8'h00, reg_wdata[22:0]};
      end else if (reg_addr == LTAC_OFS_IDX1) begin
        idx1_q <= reg_wdata;
      end else if (reg_addr == LTAC_OFS_LKCTL) begin
        lk_act_q <= reg_wdata[1:0]; // [R1]
        lk_direct_q <= reg_wdata[LTAC_BIT_DIRECT]; // [R6]
        lk_rsv_q <= reg_wdata[4:3];
      end else if (reg_addr == LTAC_OFS_SMCTL) begin
        sm_idx_q <= reg_wdata[21:16];
        sm_rsv_q <= reg_wdata[6:2];
        sm_tsel_q <= reg_wdata[LTAC_BIT_TSEL]; // [R8]
        sm_op_q <= reg_wdata[LTAC_BIT_SMOP]; // [R9]
      end
    end
  end

  // ------------------------------------------------------------
  // entry words
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        ent_q[i] <= LTAC_RST_WORD;
      end
    end else if (st_q == LTAC_ST_WAIT && bus.done && bus.valid) begin
      if (sm_active_q && sm_tsel_q) begin
        ent_q[1] <= bus.rdata[63:32]; // [R11]
      end else begin
        for (int i = 0; i < 4; i++) begin
          ent_q[i] <= bus.rdata[32*i +: 32]; // [R12]
        end
      end
    end else if (word_wr && !eng_busy && reg_addr >= LTAC_OFS_ENT1
                 && reg_addr <= LTAC_OFS_ENT4) begin
      ent_q[reg_addr[3:2]] <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  wire is_read = sm_active_q ? sm_op_q : (lk_act_q != LTAC_ACT_WRITE);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= LTAC_ST_IDLE;
      sm_active_q <= 1'b0;
      lk_go_q <= 1'b0;
      sm_go_q <= 1'b0;
      lk_rdy_q <= 1'b0;
      lk_end_q <= 1'b0;
      lk_cnt_q <= '0;
    end else begin
      case (st_q)
        LTAC_ST_IDLE: begin
          if (lk_start) begin
            lk_go_q <= 1'b1; // [R2]
            lk_rdy_q <= 1'b0;
            lk_end_q <= 1'b0;
            sm_active_q <= 1'b0;
            st_q <= LTAC_ST_REQ;
          end else if (sm_start) begin
            sm_go_q <= 1'b1; // [R10]
            sm_active_q <= 1'b1;
            st_q <= LTAC_ST_REQ;
          end
        end
        LTAC_ST_REQ: begin
          st_q <= LTAC_ST_WAIT;
        end
        LTAC_ST_WAIT: begin
          if (bus.done) begin
            if (!sm_active_q && lk_act_q == LTAC_ACT_SEARCH) begin
              if (bus.last) begin
                lk_cnt_q <= bus.count; // [R5]
                lk_end_q <= 1'b1;
                lk_go_q <= 1'b0; // [R16]
                st_q <= LTAC_ST_IDLE;
              end else begin
                lk_rdy_q <= 1'b1; // [R3]
                st_q <= LTAC_ST_HOLD;
              end
            end else begin
              lk_go_q <= 1'b0; // [R2]
              sm_go_q <= 1'b0; // [R10]
              st_q <= LTAC_ST_IDLE;
            end
          end
        end
        LTAC_ST_HOLD: begin
          if (ent4_rd) begin
            lk_rdy_q <= 1'b0; // [R3]
            st_q <= LTAC_ST_REQ; // [R16]
          end
        end
        default: st_q <= LTAC_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // engine request
  // ------------------------------------------------------------
  always_comb begin
    bus.req = (st_q == LTAC_ST_REQ);
    bus.op = sm_active_q ? (is_read ? LTAC_ACT_READ : LTAC_ACT_WRITE) : lk_act_q; // [R1]
    bus.direct = !sm_active_q && lk_direct_q; // [R6]
    bus.index = idx1_q[LTAC_DIRECT_W-1:0]; // [R14]
    if (sm_active_q) begin
      bus.index = sm_tsel_q ? {6'h00, sm_idx_q} // [R7]
        : {8'h00, sm_idx_q[LTAC_STIDX_W-1:0]}; // [R7]
    end
    bus.group_id = idx0_q[LTAC_FGID_LSB +: LTAC_FGID_W]; // [R13]
    bus.key = {idx0_q[15:0], idx1_q}; // [R13]
    bus.table_sel = sm_active_q ? {1'b1, sm_tsel_q} : 2'h0; // [R8]
    bus.wdata = {ent_q[3], ent_q[2], ent_q[1], ent_q[0]}; // [R11]
  end

  ltac_req_stage u_stage (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus(bus.stage),
    .eng_req(eng_req),
    .eng_op(eng_op),
    .eng_direct(eng_direct),
    .eng_index(eng_index),
    .eng_group_id(eng_group_id),
    .eng_key(eng_key),
    .eng_table(eng_table),
    .eng_wdata(eng_wdata),
    .eng_ack(eng_ack),
    .eng_valid(eng_valid),
    .eng_last(eng_last),
    .eng_rdata(eng_rdata),
    .eng_count(eng_count)
  );

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (reg_addr == LTAC_OFS_IDX0) begin
      rd_d = idx0_q;
    end else if (reg_addr == LTAC_OFS_IDX1) begin
      rd_d = idx1_q;
    end else if (reg_addr == LTAC_OFS_LKCTL) begin
      rd_d = {2'h0, lk_cnt_q, 8'h00, lk_go_q, lk_rdy_q,
        lk_rdy_q | lk_end_q, lk_rsv_q, lk_direct_q, lk_act_q}; // [R4]
    end else if (reg_addr == LTAC_OFS_SMCTL) begin
      rd_d = {10'h000, sm_idx_q, 8'h00, sm_go_q, sm_rsv_q, sm_tsel_q, sm_op_q};
    end else if (reg_addr >= LTAC_OFS_ENT1 && reg_addr <= LTAC_OFS_ENT4_LAST) begin
      rd_d = ent_q[reg_addr[3:2]];
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= LTAC_RST_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_d;
      end
    end
  end
endmodule : ltac_ctrl
`default_nettype wire

/* File: ltac_ctrl_properties.sv */
// port checker for the lookup table access controller
// assumes it is bound to ltac_ctrl on one clock domain
`timescale 1ns/1ps
`default_nettype none
module ltac_ctrl_properties
  import ltac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // engine side
  input wire logic eng_req,
  input wire logic [1:0] eng_op,
  input wire logic [1:0] eng_table
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // --------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------
  sequence s_lk_rd;
    reg_rd && reg_addr == LTAC_OFS_LKCTL;
  endsequence
  sequence s_sm_rd;
    reg_rd && reg_addr == LTAC_OFS_SMCTL;
  endsequence
  sequence s_advance;
    reg_rd && reg_addr[15:2] == LTAC_OFS_ENT4[15:2] ##2 s_lk_rd;
  endsequence
  property p_rvalid_follows;
    reg_rd |=> reg_rvalid;
  endproperty
  property p_rvalid_alone;
    !reg_rd |=> !reg_rvalid;
  endproperty
  property p_req_pulse;
    eng_req |=> !eng_req;
  endproperty
  property p_req_op;
    eng_req |-> eng_op != LTAC_ACT_NOP;
  endproperty
  property p_table_code;
    eng_req |-> eng_table != 2'h1;
  endproperty
  property p_combined;
    s_lk_rd |=> (reg_rdata[LTAC_BIT_RDY] -> reg_rdata[LTAC_BIT_RDY_OR_END]);
  endproperty
  property p_rdy_in_op;
    s_lk_rd |=> (reg_rdata[LTAC_BIT_RDY] -> reg_rdata[LTAC_BIT_GO]);
  endproperty
  property p_lk_reserved;
    s_lk_rd |=> reg_rdata[31:30] == 2'h0 && reg_rdata[15:8] == 8'h00;
  endproperty
  property p_sm_reserved;
    s_sm_rd |=> reg_rdata[31:22] == 10'h000 && reg_rdata[15:8] == 8'h00;
  endproperty
  property p_rdy_clear;
    s_advance |=> !reg_rdata[LTAC_BIT_RDY];
  endproperty
  a_rvalid_follows: assert property (p_rvalid_follows) else $error("read answer missing");
  a_rvalid_alone: assert property (p_rvalid_alone) else $error("read answer unasked");
  a_req_pulse: assert property (p_req_pulse) else $error("engine request too long");
  a_req_op: assert property (p_req_op) else $error("engine request without action");
  a_table_code: assert property (p_table_code) else $error("bad table code");
  a_combined: assert property (p_combined) else $error("combined flag low");
  a_rdy_in_op: assert property (p_rdy_in_op) else $error("ready outside search");
  a_lk_reserved: assert property (p_lk_reserved) else $error("lookup reserved set");
  a_sm_reserved: assert property (p_sm_reserved) else $error("static reserved set");
  a_rdy_clear: assert property (p_rdy_clear) else $error("ready kept after word 4");
endmodule : ltac_ctrl_properties
bind ltac_ctrl ltac_ctrl_properties u_props (.clk_sys(clk_sys), .reset(reset),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .eng_req(eng_req), .eng_op(eng_op), .eng_table(eng_table));
`default_nettype wire

/* File: lookup_table_access_ctrl_tb_top.sv */
// self-checking bench for the lookup table access controller
// assumes ltac_ctrl as top with its checker bound; bench plays the engine
`timescale 1ns/1ps
`default_nettype none
module lookup_table_access_ctrl_tb_top;
  import ltac_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic eng_ack = 1'b0;
  logic eng_valid = 1'b0;
  logic eng_last = 1'b0;
  logic [127:0] eng_rdata = '0;
  logic [13:0] eng_count = 14'h0000;
  logic [31:0] reg_rdata;
  logic reg_rvalid, eng_req, eng_direct;
  logic [1:0] eng_op, eng_table;
  logic [11:0] eng_index;
  logic [6:0] eng_group_id;
  logic [47:0] eng_key;
  logic [127:0] eng_wdata;
  int n_errors = 0;
  int checks_done = 0;
  int n_req = 0;
  int n_ans = 0;
  ltac_ctrl dut (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .eng_req(eng_req), .eng_op(eng_op), .eng_direct(eng_direct),
    .eng_index(eng_index), .eng_group_id(eng_group_id), .eng_key(eng_key),
    .eng_table(eng_table), .eng_wdata(eng_wdata),
    .eng_ack(eng_ack), .eng_valid(eng_valid), .eng_last(eng_last),
    .eng_rdata(eng_rdata), .eng_count(eng_count));
  initial forever #25 clk_sys = ~clk_sys;
  // counts request pulses so a short pulse is never missed
  always @(posedge clk_sys) begin
    if (eng_req === 1'b1)
      n_req <= n_req + 1;
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic complete_run();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 1'b1, reg_rvalid);
    d = reg_rdata;
  endtask : rd
  // bounded poll until a status bit reads the wanted level
  task automatic poll(input logic [15:0] a, input int b, input logic v);
    logic [31:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(a, d);
      if (d[b] === v)
        return;
    end
    chk("poll timeout", 1'b0, 1'b1);
    complete_run();
  endtask : poll
  // engine stand-in: waits for a request, then acks once
  task automatic answer(input logic v, input logic l, input logic [127:0] d,
    input logic [13:0] c);
    for (int i = 0; i < 20 && n_req <= n_ans; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n_req <= n_ans) begin
      chk("request timeout", 1'b0, 1'b1);
      complete_run();
    end else begin
      n_ans++;
      @(posedge clk_sys);
      eng_ack <= 1'b1;
      eng_valid <= v;
      eng_last <= l;
      eng_rdata <= d;
      eng_count <= c;
      @(posedge clk_sys);
      eng_ack <= 1'b0;
    end
  endtask : answer
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] d, lo;
    logic [15:0] hi;
    logic [6:0] g;
    logic [127:0] e;
    logic [13:0] c;
    logic [5:0] x;
    logic [15:0] ra[4] = '{LTAC_OFS_LKCTL, LTAC_OFS_SMCTL, LTAC_OFS_ENT1, 16'h0500};
    lo = $urandom(32'h60CC);
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (ra[k]) begin
      rd(ra[k], d);
      chk("reset word", LTAC_RST_WORD, d);
    end
    for (int i = 0; i < 4; i++) begin
      lo = $urandom;
      hi = $urandom;
      g = $urandom;
      e = {$urandom, $urandom, $urandom, $urandom};
      for (int k = 0; k < 4 && !i[0]; k++)
        wr(LTAC_OFS_ENT1 + 16'(k * 4), e[k*32 +: 32]);
      wr(LTAC_OFS_IDX0, {9'h000, g, hi});
      wr(LTAC_OFS_IDX1, lo);
      wr(LTAC_OFS_LKCTL, {24'h00_0000, 1'b1, 4'h0, i[1], i[0] ? 2'h2 : 2'h1});
      answer(i[0], 1'b0, e, 14'h0000);
      poll(LTAC_OFS_LKCTL, LTAC_BIT_GO, 1'b0);
      chk("op", i[0] ? 2'h2 : 2'h1, eng_op);
      chk("direct", i[1], eng_direct);
      chk("table", 2'h0, eng_table);
      if (i[1])
        chk("index", lo[11:0], eng_index);
      else
        chk("key", {g, hi, lo}, {eng_group_id, eng_key});
      if (!i[0]) begin
        chk("wdata lo", e[63:0], eng_wdata[63:0]);
        chk("wdata hi", e[127:64], eng_wdata[127:64]);
      end
      for (int k = 0; k < 4 && i[0]; k++) begin
        rd(LTAC_OFS_ENT1 + 16'(k * 4), d);
        chk("entry", e[k*32 +: 32], d);
      end
    end
    wr(LTAC_OFS_LKCTL, 32'h0000_0080);
    rd(LTAC_OFS_LKCTL, d);
    chk("nop go", 1'b0, d[LTAC_BIT_GO]);
    e = {$urandom, $urandom, $urandom, $urandom};
    wr(LTAC_OFS_LKCTL, 32'h0000_0083);
    answer(1'b1, 1'b0, e, 14'h0000);
    poll(LTAC_OFS_LKCTL, LTAC_BIT_RDY, 1'b1);
    rd(LTAC_OFS_LKCTL, d);
    chk("search flags", 3'h7, d[7:5]);
    rd(LTAC_OFS_ENT1, d);
    chk("held word 1", e[31:0], d);
    rd(LTAC_OFS_ENT4_LAST, d);
    chk("held word 4", e[127:96], d);
    rd(LTAC_OFS_LKCTL, d);
    chk("ready cleared", 1'b0, d[LTAC_BIT_RDY]);
    c = $urandom;
    answer(1'b0, 1'b1, e, c);
    poll(LTAC_OFS_LKCTL, LTAC_BIT_GO, 1'b0);
    rd(LTAC_OFS_LKCTL, d);
    chk("count", c, d[29:16]);
    chk("ended", 1'b1, d[LTAC_BIT_RDY_OR_END]);
    for (int j = 0; j < 4; j++) begin
      x = $urandom;
      e = {$urandom, $urandom, $urandom, $urandom};
      if (!j[0]) begin
        lo = e[31:0];
        for (int k = 0; k < 4; k++)
          wr(LTAC_OFS_ENT1 + 16'(k * 4), e[k*32 +: 32]);
      end
      wr(LTAC_OFS_SMCTL, {10'h000, x, 8'h00, 1'b1, 5'h00, j[1], j[0]});
      answer(j[0], 1'b0, e, 14'h0000);
      poll(LTAC_OFS_SMCTL, LTAC_BIT_GO, 1'b0);
      chk("sm table", {1'b1, j[1]}, eng_table);
      chk("sm op", j[0] ? 2'h2 : 2'h1, eng_op);
      chk("sm index", j[1] ? x : {2'h0, x[3:0]}, eng_index);
      if (j[0]) begin
        rd(LTAC_OFS_ENT2, d);
        chk("sm word 2", e[63:32], d);
        if (j[1]) begin
          rd(LTAC_OFS_ENT1, d);
          chk("rm word 1 kept", lo, d);
        end
      end else if (j[1]) begin
        chk("rm wdata", e[63:32], eng_wdata[63:32]);
      end else begin
        chk("st wdata lo", e[63:0], eng_wdata[63:0]);
        chk("st wdata hi", e[127:64], eng_wdata[127:64]);
      end
    end
    complete_run();
  end
endmodule : lookup_table_access_ctrl_tb_top
`default_nettype wire
